// ### vsc_defs.svh
`ifndef VSC_DEFS_SVH
`define VSC_DEFS_SVH

// ----------------------------------------
// Register offsets on the serial control bus
// ----------------------------------------
`define VSC_OFS_IDENT 8'h3d
`define VSC_OFS_FILLER 8'h3e
`define VSC_OFS_TT_CTRL 8'h3f
`define VSC_OFS_FRAME_CODE 8'h40
`define VSC_OFS_PID_WSS 8'h41
`define VSC_OFS_CC_GD 8'h42
`define VSC_OFS_LAST 8'h42
`define VSC_NUM_REGS 6

// ----------------------------------------
// Reset values
// ----------------------------------------
`define VSC_RST_IDENT 8'h01
`define VSC_RST_FILLER 8'h00
`define VSC_RST_TT_CTRL 8'h81
`define VSC_RST_FRAME_CODE 8'h00
`define VSC_RST_PID_WSS 8'hc5
`define VSC_RST_CC_GD 8'h00
`define VSC_RD_UNMAPPED 8'h00

// ----------------------------------------
// Field positions
// ----------------------------------------
`define VSC_ID_MSB 5
`define VSC_FIL_MSB 5
`define VSC_TT_ADAPT_BIT 6
`define VSC_TT_RAWBYP_BIT 5
`define VSC_TT_EN_BIT 4
`define VSC_TT_CUSTOM_BIT 2
`define VSC_TT_EXT_BIT 1
`define VSC_TT_ALL_BIT 0
`define VSC_WSS_F1_BIT 7
`define VSC_PID_F1_BIT 6
`define VSC_PID_EN_BIT 3
`define VSC_PID_EXT_BIT 2
`define VSC_WSS_EN_BIT 1
`define VSC_WSS_EXT_BIT 0
`define VSC_GD_BASE 4
`define VSC_CC_BASE 0
`define VSC_SVC_FULL_OFS 2
`define VSC_SVC_RELAX_OFS 1
`define VSC_SVC_EN_OFS 0

// ----------------------------------------
// Line numbers of the service windows
// ----------------------------------------
`define VSC_TT_EXT_LINE 10'd2
`define VSC_TT_NORM_LINE 10'd7
`define VSC_PID_LINE 10'd16
`define VSC_PID_LINE_LO 10'd15
`define VSC_PID_LINE_HI 10'd17
`define VSC_WSS_LINE 10'd23
`define VSC_WSS_LINE_LO 10'd21
`define VSC_WSS_LINE_HI 10'd24
`define VSC_CAP_LINE_60 10'd21
`define VSC_CAP_LINE_50 10'd22

// Bus device address, arbitrary value
`define VSC_DEV_ADDR 7'h2a

`endif

// ### vsc_pkg.sv
package vsc_pkg;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef logic [7:0] vsc_byte_t;
  typedef logic [9:0] vsc_line_t;

  typedef enum logic [8:0] {
    VSC_IDLE     = 9'h001,
    VSC_ADDR     = 9'h002,
    VSC_ADDR_ACK = 9'h004,
    VSC_SUB      = 9'h008,
    VSC_SUB_ACK  = 9'h010,
    VSC_WDATA    = 9'h020,
    VSC_WR_ACK   = 9'h040,
    VSC_RDATA    = 9'h080,
    VSC_RD_ACK   = 9'h100
  } vsc_state_t;

endpackage : vsc_pkg

// ### vsc_bus_edges.sv
`timescale 1ns/1ps
// ----------------------------------------
// Serial bus edge and condition detect
// ----------------------------------------
module vsc_bus_edges (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_rise_o,
  output logic scl_fall_o,
  output logic start_o,
  output logic stop_o
);
  logic scl_ff;
  logic sda_ff;

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      scl_ff <= 1'b1;
      sda_ff <= 1'b1;
    end
    else if (ce_i)
    begin
      scl_ff <= scl_i;
      sda_ff <= sda_i;
    end
  end

  assign scl_rise_o = ce_i & scl_i & ~scl_ff;
  assign scl_fall_o = ce_i & ~scl_i & scl_ff;
  // Data may only move while clock is low, so a change with clock high is a condition
  assign start_o = ce_i & scl_i & scl_ff & sda_ff & ~sda_i;
  assign stop_o = ce_i & scl_i & scl_ff & ~sda_ff & sda_i;
endmodule : vsc_bus_edges

// ### vsc_svc_window.sv
`timescale 1ns/1ps
`include "vsc_defs.svh"
// ----------------------------------------
// Per-service line window qualifiers
// ----------------------------------------
module vsc_svc_window (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire vsc_pkg::vsc_line_t line_i,
  input wire logic vbi_i,
  input wire logic rate_50hz_i,
  input wire vsc_pkg::vsc_byte_t tt_ctrl_i,
  input wire vsc_pkg::vsc_byte_t pid_wss_i,
  input wire vsc_pkg::vsc_byte_t cc_gd_i,
  output logic tt_win_o,
  output logic pid_win_o,
  output logic wss_win_o,
  output logic [1:0] capgd_win_o
);
  import vsc_pkg::*;

  logic tt_ff;
  logic pid_ff;
  logic wss_ff;
  logic [1:0] capgd_ff;
  logic nxt_tt;
  logic nxt_pid;
  logic nxt_wss;
  logic [1:0] nxt_capgd;
  logic single_line;
  vsc_line_t tt_first;

  assign tt_first = tt_ctrl_i[`VSC_TT_EXT_BIT] ? `VSC_TT_EXT_LINE : `VSC_TT_NORM_LINE;
  assign nxt_tt = tt_ctrl_i[`VSC_TT_EN_BIT] & vbi_i & (line_i >= tt_first);
  assign nxt_pid = pid_wss_i[`VSC_PID_EN_BIT] & (pid_wss_i[`VSC_PID_EXT_BIT] ?
    (line_i >= `VSC_PID_LINE_LO && line_i <= `VSC_PID_LINE_HI) : (line_i == `VSC_PID_LINE));
  assign nxt_wss = pid_wss_i[`VSC_WSS_EN_BIT] & (pid_wss_i[`VSC_WSS_EXT_BIT] ?
    (line_i >= `VSC_WSS_LINE_LO && line_i <= `VSC_WSS_LINE_HI) : (line_i == `VSC_WSS_LINE));
  assign single_line = line_i == (rate_50hz_i ? `VSC_CAP_LINE_50 : `VSC_CAP_LINE_60);

  // ----------------------------------------
  // Caption (0) and guide (1) share one layout
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_capgd
      localparam int BASE = (g == 0) ? `VSC_CC_BASE : `VSC_GD_BASE;
      assign nxt_capgd[g] = cc_gd_i[BASE + `VSC_SVC_EN_OFS] &
        (cc_gd_i[BASE + `VSC_SVC_FULL_OFS] ? vbi_i : single_line);
    end
  endgenerate

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      tt_ff <= 1'b0;
      pid_ff <= 1'b0;
      wss_ff <= 1'b0;
      capgd_ff <= 2'h0;
    end
    else if (ce_i)
    begin
      tt_ff <= nxt_tt;
      pid_ff <= nxt_pid;
      wss_ff <= nxt_wss;
      capgd_ff <= nxt_capgd;
    end
  end

  assign tt_win_o = tt_ff;
  assign pid_win_o = pid_ff;
  assign wss_win_o = wss_ff;
  assign capgd_win_o = capgd_ff;
endmodule : vsc_svc_window

// ### vsc_slicer_ctrl.sv
// Operation
// - Identifier field codes every ancillary packet
// - Filler field fills packet filler byte
// - Adaptive level enable drives teletext threshold
// - Raw mode Hamming filter unless bypassed
// - Teletext sliced only while enabled
// - Teletext enable also drives equalizer
// - Custom framing selects programmed code
// - Extended window starts teletext at line 2
// - All-packets bit widens beyond X/30, X/31
// - Eight-bit alternate framing code held
// - Program-id sliced only while enabled
// - Program-id line 16, or 15-17
// - Widescreen sliced only while enabled
// - Widescreen line 23, or 21-24
// - Guide single line or whole blanking
// - Guide relaxed or strict frame check
// - Guide sliced only while enabled
// - Caption single line or whole blanking
// - Caption relaxed or strict frame check
// - Caption sliced only while enabled
`timescale 1ns/1ps
`include "vsc_defs.svh"
module vsc_slicer_ctrl (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire vsc_pkg::vsc_line_t line_i,
  input wire logic vbi_i,
  input wire logic rate_50hz_i,
  output logic [5:0] packet_identifier_value_o,
  output logic [5:0] packet_filler_value_o,
  output logic adaptive_level_enable_o,
  output logic raw_filter_bypass_o,
  output logic teletext_slice_enable_o,
  output logic equalizer_enable_o,
  output logic teletext_custom_framing_o,
  output logic teletext_all_packets_o,
  output vsc_pkg::vsc_byte_t alternate_frame_code_o,
  output logic widescreen_first_field_only_o,
  output logic progid_first_field_only_o,
  output logic caption_relaxed_check_o,
  output logic guide_relaxed_check_o,
  output logic teletext_window_o,
  output logic progid_window_o,
  output logic widescreen_window_o,
  output logic caption_window_o,
  output logic guide_window_o
);
  import vsc_pkg::*;

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  localparam vsc_byte_t RST_VAL [0:`VSC_NUM_REGS-1] = '{`VSC_RST_IDENT, `VSC_RST_FILLER,
    `VSC_RST_TT_CTRL, `VSC_RST_FRAME_CODE, `VSC_RST_PID_WSS, `VSC_RST_CC_GD};

  vsc_state_t state_ff;
  vsc_state_t nxt_state;
  logic [3:0] cnt_ff;
  logic [3:0] nxt_cnt;
  vsc_byte_t sh_ff;
  vsc_byte_t nxt_sh;
  vsc_byte_t sub_ff;
  vsc_byte_t nxt_sub;
  logic rw_ff;
  logic nxt_rw;
  logic sda_oe_ff;
  logic nxt_sda_oe;
  logic sda_o_ff;
  vsc_byte_t regs_ff [0:`VSC_NUM_REGS-1];

  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic byte_done;
  logic addr_match;
  logic sub_hit;
  logic [2:0] sub_idx;
  logic wr_stb;
  vsc_byte_t rd_byte;
  vsc_byte_t sub_inc;
  logic [1:0] capgd_win;

  // ----------------------------------------
  // Bus condition detect
  // ----------------------------------------
  vsc_bus_edges u_edges (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .scl_rise_o(scl_rise),
    .scl_fall_o(scl_fall),
    .start_o(bus_start),
    .stop_o(bus_stop)
  );

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  assign byte_done = cnt_ff == 4'h8;
  assign addr_match = sh_ff[7:1] == `VSC_DEV_ADDR;
  assign sub_hit = (sub_ff >= `VSC_OFS_IDENT) && (sub_ff <= `VSC_OFS_LAST);
  assign sub_idx = 3'(sub_ff - `VSC_OFS_IDENT);
  assign sub_inc = sub_ff + 8'h01;
  // Unmapped offsets read as zero and swallow writes, but still acknowledge
  assign rd_byte = sub_hit ? regs_ff[sub_idx] : `VSC_RD_UNMAPPED;
  assign wr_stb = ce_i & (state_ff == VSC_WDATA) & scl_fall & byte_done & sub_hit;

  // ----------------------------------------
  // Serial protocol state machine
  // ----------------------------------------
  always_comb
  begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_sh = sh_ff;
    nxt_sub = sub_ff;
    nxt_rw = rw_ff;
    nxt_sda_oe = sda_oe_ff;
    if (bus_stop)
    begin
      nxt_state = VSC_IDLE;
      nxt_sda_oe = 1'b0;
    end
    else if (bus_start)
    begin
      // Repeated start keeps the offset so a read can follow an offset write
      nxt_state = VSC_ADDR;
      nxt_cnt = 4'h0;
      nxt_sda_oe = 1'b0;
    end
    else
    begin
      case (state_ff)
        VSC_IDLE:
        begin
          nxt_sda_oe = 1'b0;
        end
        VSC_ADDR, VSC_SUB, VSC_WDATA:
        begin
          if (scl_rise && !byte_done)
          begin
            nxt_sh = {sh_ff[6:0], sda_i};
            nxt_cnt = cnt_ff + 4'h1;
          end
          else if (scl_fall && byte_done)
          begin
            nxt_cnt = 4'h0;
            nxt_sda_oe = 1'b1;
            case (state_ff)
              VSC_ADDR:
              begin
                nxt_rw = sh_ff[0];
                nxt_sda_oe = addr_match;
                nxt_state = addr_match ? VSC_ADDR_ACK : VSC_IDLE;
              end
              VSC_SUB:
              begin
                nxt_sub = sh_ff;
                nxt_state = VSC_SUB_ACK;
              end
              default:
              begin
                nxt_sub = sub_inc;
                nxt_state = VSC_WR_ACK;
              end
            endcase
          end
        end
        VSC_ADDR_ACK, VSC_SUB_ACK, VSC_WR_ACK:
        begin
          if (scl_fall)
          begin
            nxt_sda_oe = 1'b0;
            nxt_state = (state_ff == VSC_ADDR_ACK) ? VSC_SUB : VSC_WDATA;
            if (state_ff == VSC_ADDR_ACK && rw_ff)
            begin
              nxt_sh = {rd_byte[6:0], 1'b0};
              nxt_sda_oe = ~rd_byte[7];
              nxt_cnt = 4'h1;
              nxt_state = VSC_RDATA;
            end
          end
        end
        VSC_RDATA:
        begin
          if (scl_fall)
          begin
            if (byte_done)
            begin
              nxt_sda_oe = 1'b0;
              nxt_sub = sub_inc;
              nxt_state = VSC_RD_ACK;
            end
            else
            begin
              nxt_sda_oe = ~sh_ff[7];
              nxt_sh = {sh_ff[6:0], 1'b0};
              nxt_cnt = cnt_ff + 4'h1;
            end
          end
        end
        VSC_RD_ACK:
        begin
          // Master acknowledge on the rising edge; a not-acknowledge ends the read
          if (scl_rise)
          begin
            nxt_rw = ~sda_i;
          end
          else if (scl_fall)
          begin
            nxt_state = rw_ff ? VSC_RDATA : VSC_IDLE;
            nxt_sh = {rd_byte[6:0], 1'b0};
            nxt_sda_oe = rw_ff & ~rd_byte[7];
            nxt_cnt = 4'h1;
          end
        end
        default:
        begin
          nxt_state = VSC_IDLE;
          nxt_sda_oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_ff <= VSC_IDLE;
      cnt_ff <= 4'h0;
      sh_ff <= 8'h00;
      sub_ff <= 8'h00;
      rw_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
      sda_o_ff <= 1'b0;
    end
    else if (ce_i)
    begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      sh_ff <= nxt_sh;
      sub_ff <= nxt_sub;
      rw_ff <= nxt_rw;
      sda_oe_ff <= nxt_sda_oe;
      sda_o_ff <= 1'b0;
    end
  end

  assign sda_o = sda_o_ff;
  assign sda_oe_o = sda_oe_ff;

  // ----------------------------------------
  // Register bank
  // ----------------------------------------
  // Reserved bits are stored as written; software is trusted to keep them
  genvar g;
  generate
    for (g = 0; g < `VSC_NUM_REGS; g++)
    begin : g_reg
      always_ff @(posedge clk_i or posedge rst_i)
      begin
        if (rst_i)
        begin
          regs_ff[g] <= RST_VAL[g];
        end
        else if (wr_stb && sub_idx == 3'(g))
        begin
          regs_ff[g] <= sh_ff;
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Field outputs
  // ----------------------------------------
  assign packet_identifier_value_o = regs_ff[0][`VSC_ID_MSB:0];
  assign packet_filler_value_o = regs_ff[1][`VSC_FIL_MSB:0];
  assign adaptive_level_enable_o = regs_ff[2][`VSC_TT_ADAPT_BIT];
  assign raw_filter_bypass_o = regs_ff[2][`VSC_TT_RAWBYP_BIT];
  assign teletext_slice_enable_o = regs_ff[2][`VSC_TT_EN_BIT];
  assign equalizer_enable_o = regs_ff[2][`VSC_TT_EN_BIT];
  assign teletext_custom_framing_o = regs_ff[2][`VSC_TT_CUSTOM_BIT];
  assign teletext_all_packets_o = regs_ff[2][`VSC_TT_ALL_BIT];
  assign alternate_frame_code_o = regs_ff[3];
  assign widescreen_first_field_only_o = regs_ff[4][`VSC_WSS_F1_BIT];
  assign progid_first_field_only_o = regs_ff[4][`VSC_PID_F1_BIT];
  assign caption_relaxed_check_o = regs_ff[5][`VSC_CC_BASE + `VSC_SVC_RELAX_OFS];
  assign guide_relaxed_check_o = regs_ff[5][`VSC_GD_BASE + `VSC_SVC_RELAX_OFS];

  // ----------------------------------------
  // Line windows
  // ----------------------------------------
  vsc_svc_window u_window (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .line_i(line_i),
    .vbi_i(vbi_i),
    .rate_50hz_i(rate_50hz_i),
    .tt_ctrl_i(regs_ff[2]),
    .pid_wss_i(regs_ff[4]),
    .cc_gd_i(regs_ff[5]),
    .tt_win_o(teletext_window_o),
    .pid_win_o(progid_window_o),
    .wss_win_o(widescreen_window_o),
    .capgd_win_o(capgd_win)
  );

  assign caption_window_o = capgd_win[0];
  assign guide_window_o = capgd_win[1];
endmodule : vsc_slicer_ctrl

// ### vsc_video_src.sv
`timescale 1ns/1ps
// ----------------------------------------
// Video source model, short frames
// ----------------------------------------
module vsc_video_src #(
  parameter int LINES = 40
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic sel_50hz_i,
  output vsc_pkg::vsc_line_t line_o,
  output logic vbi_o,
  output logic rate_50hz_o
);
  import vsc_pkg::*;
  // Short frame so that every window line comes round often
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      line_o <= 10'h001;
    else
      line_o <= (line_o == 10'(LINES)) ? 10'h001 : line_o + 10'h001;
  end
  assign vbi_o = (line_o <= 10'h019);
  assign rate_50hz_o = sel_50hz_i;
endmodule : vsc_video_src

// ### vsc_slicer_ctrl_sva.sv
`timescale 1ns/1ps
// ----------------------------------------
// Port checker
// ----------------------------------------
module vsc_slicer_ctrl_sva (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic sda_oe_o,
  input wire vsc_pkg::vsc_line_t line_i,
  input wire logic vbi_i,
  input wire logic [5:0] packet_identifier_value_o,
  input wire logic [5:0] packet_filler_value_o,
  input wire logic teletext_slice_enable_o,
  input wire logic equalizer_enable_o,
  input wire vsc_pkg::vsc_byte_t alternate_frame_code_o,
  input wire logic progid_first_field_only_o,
  input wire logic teletext_window_o,
  input wire logic progid_window_o,
  input wire logic widescreen_window_o,
  input wire logic caption_window_o,
  input wire logic guide_window_o
);
  import vsc_pkg::*;
  logic [22:0] fv;
  assign fv = {packet_identifier_value_o, packet_filler_value_o, teletext_slice_enable_o, equalizer_enable_o,
    alternate_frame_code_o, progid_first_field_only_o};
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Fields may only move with the ack of a data byte
  sequence s_ack_rise;
    $rose(sda_oe_o);
  endsequence
  AST_RESET_VALUES: assert property ($fell(rst_i) |-> fv == {6'h01, 6'h00, 2'b00, 8'h00, 1'b1})
    else $error("fields differ from reset values");
  AST_FIELDS_HOLD: assert property ($changed(fv) |-> s_ack_rise)
    else $error("field changed without a write ack");
  AST_CE_FREEZE: assert property (!ce_i |=> $stable(fv) && $stable({teletext_window_o, progid_window_o,
    widescreen_window_o, caption_window_o, guide_window_o}))
    else $error("state moved while clock enable low");
  AST_EQ_TRACKS: assert property (equalizer_enable_o == teletext_slice_enable_o)
    else $error("equalizer enable differs from teletext enable");
  AST_TT_OFF: assert property (ce_i && !teletext_slice_enable_o |=> !teletext_window_o)
    else $error("teletext window open while disabled");
  AST_TT_EARLY: assert property (ce_i && (line_i < 10'd2 || !vbi_i) |=> !teletext_window_o)
    else $error("teletext window before line 2 or outside blanking");
  AST_PID_LINES: assert property (ce_i && (line_i < 10'd15 || line_i > 10'd17) |=> !progid_window_o)
    else $error("program id window outside lines 15 to 17");
  AST_WSS_LINES: assert property (ce_i && (line_i < 10'd21 || line_i > 10'd24) |=> !widescreen_window_o)
    else $error("widescreen window outside lines 21 to 24");
  AST_CAP_LINES: assert property (ce_i && !vbi_i && line_i != 10'd21 && line_i != 10'd22 |=> !caption_window_o)
    else $error("caption window off its line");
  AST_GD_LINES: assert property (ce_i && !vbi_i && line_i != 10'd21 && line_i != 10'd22 |=> !guide_window_o)
    else $error("guide window off its line");
endmodule : vsc_slicer_ctrl_sva

bind vsc_slicer_ctrl vsc_slicer_ctrl_sva u_sva (.clk_i, .rst_i, .ce_i, .sda_oe_o, .line_i, .vbi_i,
  .packet_identifier_value_o, .packet_filler_value_o, .teletext_slice_enable_o, .equalizer_enable_o,
  .alternate_frame_code_o, .progid_first_field_only_o, .teletext_window_o, .progid_window_o,
  .widescreen_window_o, .caption_window_o, .guide_window_o);

// ### testbench.sv
`timescale 1ns/1ps
`include "vsc_defs.svh"
module testbench;
  import vsc_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, scl_i = 1'b1, sda_m = 1'b1, sel_50hz = 1'b0;
  logic sda_i, sda_o, sda_oe_o, vbi_i, rate_50hz_i;
  logic [5:0] packet_identifier_value_o, packet_filler_value_o;
  logic adaptive_level_enable_o, raw_filter_bypass_o, teletext_slice_enable_o, equalizer_enable_o;
  logic teletext_custom_framing_o, teletext_all_packets_o, widescreen_first_field_only_o;
  logic progid_first_field_only_o, caption_relaxed_check_o, guide_relaxed_check_o;
  logic teletext_window_o, progid_window_o, widescreen_window_o, caption_window_o, guide_window_o;
  vsc_line_t line_i;
  vsc_byte_t alternate_frame_code_o, o, d;
  vsc_byte_t rm [6];
  logic [29:0] fld;
  logic [4:0] win;
  logic [8:0] q9;
  logic [29:0] fq;
  logic [15:0] corner [8] = '{16'h3ff7, 16'h41cf, 16'h4277, 16'h43a5, 16'h3f90, 16'h41ca, 16'h4211, 16'h40c3};
  int fail_count = 0, n_checks = 0;
  // ----------------------------------------
  // Wiring
  // ----------------------------------------
  // Open drain with pull-up: either party may pull low
  assign sda_i = sda_m & ~sda_oe_o;
  assign fld = {packet_identifier_value_o, packet_filler_value_o, adaptive_level_enable_o, raw_filter_bypass_o,
    teletext_slice_enable_o, equalizer_enable_o, teletext_custom_framing_o, teletext_all_packets_o,
    alternate_frame_code_o, widescreen_first_field_only_o, progid_first_field_only_o, caption_relaxed_check_o,
    guide_relaxed_check_o};
  assign win = {teletext_window_o, progid_window_o, widescreen_window_o, caption_window_o, guide_window_o};
  always #2.5 clk_i = ~clk_i;
  vsc_slicer_ctrl dut (.clk_i, .rst_i, .ce_i, .scl_i, .sda_i, .sda_o, .sda_oe_o, .line_i, .vbi_i, .rate_50hz_i,
    .packet_identifier_value_o, .packet_filler_value_o, .adaptive_level_enable_o, .raw_filter_bypass_o,
    .teletext_slice_enable_o, .equalizer_enable_o, .teletext_custom_framing_o, .teletext_all_packets_o,
    .alternate_frame_code_o, .widescreen_first_field_only_o, .progid_first_field_only_o,
    .caption_relaxed_check_o, .guide_relaxed_check_o, .teletext_window_o, .progid_window_o,
    .widescreen_window_o, .caption_window_o, .guide_window_o);
  vsc_video_src src (.clk_i, .rst_i, .sel_50hz_i(sel_50hz), .line_o(line_i), .vbi_o(vbi_i),
    .rate_50hz_o(rate_50hz_i));
  // ----------------------------------------
  // Bus and compare tasks
  // ----------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : cyc
  task automatic cmp_bus(input vsc_byte_t got, input vsc_byte_t exp, input string m);
    n_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask : cmp_bus
  task automatic cmp_port(input logic [29:0] got, input logic [29:0] exp, input string m);
    n_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask : cmp_port
  task automatic start();
    sda_m = 1'b1;
    cyc(2);
    scl_i = 1'b1;
    cyc(4);
    sda_m = 1'b0;
    cyc(4);
    scl_i = 1'b0;
    cyc(2);
  endtask : start
  task automatic stop();
    sda_m = 1'b0;
    cyc(2);
    scl_i = 1'b1;
    cyc(4);
    sda_m = 1'b1;
    cyc(4);
  endtask : stop
  // Nine clocks per byte; data changes only while scl is low
  task automatic xfer(input logic [8:0] b, output logic [8:0] q);
    for (int i = 8; i >= 0; i--)
    begin
      sda_m = b[i];
      cyc(4);
      scl_i = 1'b1;
      cyc(4);
      q[i] = sda_i;
      scl_i = 1'b0;
      cyc(2);
    end
  endtask : xfer
  task automatic head(input vsc_byte_t ofs);
    logic [8:0] q;
    start();
    xfer({`VSC_DEV_ADDR, 2'b01}, q);
    cmp_bus({7'h00, q[0]}, 8'h00, "address ack");
    xfer({ofs, 1'b1}, q);
    cmp_bus({7'h00, q[0]}, 8'h00, "offset ack");
  endtask : head
  task automatic wr(input vsc_byte_t ofs, input vsc_byte_t v);
    logic [8:0] q;
    head(ofs);
    xfer({v, 1'b1}, q);
    stop();
    if (ofs >= `VSC_OFS_IDENT && ofs <= `VSC_OFS_LAST) rm[ofs - `VSC_OFS_IDENT] = v;
  endtask : wr
  task automatic rd(input vsc_byte_t ofs, output vsc_byte_t v);
    logic [8:0] q;
    head(ofs);
    start();
    xfer({`VSC_DEV_ADDR, 2'b11}, q);
    xfer(9'h1ff, q);
    v = q[8:1];
    stop();
  endtask : rd
  // ----------------------------------------
  // Expected values
  // ----------------------------------------
  function automatic vsc_byte_t exp_rd(input vsc_byte_t ofs);
    return (ofs >= `VSC_OFS_IDENT && ofs <= `VSC_OFS_LAST) ? rm[ofs - `VSC_OFS_IDENT] : 8'h00;
  endfunction : exp_rd
  function automatic logic [29:0] exp_fld();
    return {rm[0][5:0], rm[1][5:0], rm[2][6:4], rm[2][4], rm[2][2], rm[2][0], rm[3], rm[4][7:6], rm[5][1], rm[5][5]};
  endfunction : exp_fld
  function automatic logic [4:0] exp_win(input vsc_line_t l, input logic v, input logic r);
    logic sl;
    sl = (l == (r ? 10'd22 : 10'd21));
    return {rm[2][4] & v & (l >= (rm[2][1] ? 10'd2 : `VSC_TT_NORM_LINE)),
      rm[4][3] & (rm[4][2] ? (l >= 10'd15 && l <= 10'd17) : l == 10'd16),
      rm[4][1] & (rm[4][0] ? (l >= 10'd21 && l <= 10'd24) : l == 10'd23),
      rm[5][0] & (rm[5][2] ? v : sl), rm[5][4] & (rm[5][6] ? v : sl)};
  endfunction : exp_win
  task automatic chk();
    vsc_line_t l;
    logic v, r;
    vsc_byte_t x;
    for (int i = 0; i < 8; i++)
    begin
      rd(8'h3c + 8'(i), x);
      cmp_bus(x, exp_rd(8'h3c + 8'(i)), "register read");
    end
    cmp_port(fld, exp_fld(), "field outputs");
    cmp_port({29'h0, sda_o}, 30'h0, "data drive level");
    for (int k = 0; k < 90; k++)
    begin
      sel_50hz = (k >= 45);
      l = line_i;
      v = vbi_i;
      r = rate_50hz_i;
      cyc(1);
      cmp_port({25'h0, win}, {25'h0, exp_win(l, v, r)}, "windows");
    end
  endtask : chk
  // ----------------------------------------
  // Sequence and verdict
  // ----------------------------------------
  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict
  initial
  begin
    void'($urandom(6));
    rm = '{8'h01, 8'h00, 8'h81, 8'h00, 8'hc5, 8'h00};
    cyc(20);
    rst_i = 1'b0;
    chk();
    foreach (corner[i])
    begin
      wr(corner[i][15:8], corner[i][7:0]);
      chk();
    end
    for (int n = 0; n < 10; n++)
    begin
      o = 8'h3d + 8'($urandom_range(5));
      d = 8'($urandom);
      if (o < 8'h3f) d[7:6] = 2'b00;
      if (o == 8'h3f) d[7] = 1'b1;
      if (o == 8'h41) d[5:4] = 2'b00;
      wr(o, d);
      chk();
    end
    // Foreign address: no ack, and the bytes behind it must not land
    start();
    xfer({`VSC_DEV_ADDR ^ 7'h01, 2'b01}, q9);
    cmp_bus({7'h00, q9[0]}, 8'h01, "foreign address nack");
    xfer({8'h3d, 1'b1}, q9);
    xfer(9'h07f, q9);
    stop();
    // Burst read: master ack moves on to the next offset
    head(8'h3d);
    start();
    xfer({`VSC_DEV_ADDR, 2'b11}, q9);
    xfer(9'h1fe, q9);
    cmp_bus(q9[8:1], exp_rd(8'h3d), "burst read first");
    xfer(9'h1ff, q9);
    cmp_bus(q9[8:1], exp_rd(8'h3e), "burst read second");
    stop();
    // Clock enable low freezes fields and windows while the line moves on
    ce_i = 1'b0;
    o = {3'h0, win};
    fq = fld;
    cyc(60);
    cmp_port({25'h0, win}, {25'h0, o[4:0]}, "frozen windows");
    cmp_port(fld, fq, "frozen fields");
    ce_i = 1'b1;
    chk();
    print_verdict();
  end
  // Budget above the roughly 71k cycles the sequence needs
  initial
  begin
    repeat (95000) @(posedge clk_i);
    fail_count++;
    print_verdict();
  end
endmodule : testbench
